// ---- rtl/eq3rl_defines.svh ----
// Offsets, field positions, reset values and timing counts for the
// queue-3 egress limit register bank (queue 3 is top priority in four-queue mode).
// Assumes a 100 MHz switch system clock and byte-wide direct register access.
`ifndef EQ3RL_DEFINES_SVH
`define EQ3RL_DEFINES_SVH

// =====================================================================
// Register offsets.
`define EQ3RL_OFS_LIM_P1 8'hBE
`define EQ3RL_OFS_LIM_P2 8'hCE
`define EQ3RL_OFS_LIM_P3 8'hDE
`define EQ3RL_OFS_LIM_P4 8'hEE
`define EQ3RL_OFS_LIM_P5 8'hFE
`define EQ3RL_OFS_FIX_1 8'hBF
`define EQ3RL_OFS_FIX_2 8'hCF
`define EQ3RL_OFS_FIX_3 8'hDF
`define EQ3RL_OFS_FIX_4 8'hEF
`define EQ3RL_OFS_FIX_5 8'hFF

// =====================================================================
// Field layout and reset values.
`define EQ3RL_CODE_MSB 6
`define EQ3RL_RST_CODE 7'h00
`define EQ3RL_RST_FIX_1 8'h80
`define EQ3RL_RST_FIX_2 8'h15
`define EQ3RL_RST_FIX_3 8'h0C
`define EQ3RL_RST_FIX_4 8'h32
`define EQ3RL_RST_FIX_5 8'h00
`define EQ3RL_NPORT 5

// =====================================================================
// Timing: one credit tick per microsecond, credit ceiling in bytes.
`define EQ3RL_CLK_NS 10
`define EQ3RL_TICK_NS 1000
`define EQ3RL_TICK_CYC (`EQ3RL_TICK_NS / `EQ3RL_CLK_NS)
`define EQ3RL_CREDIT_MAX 12'h7FF

`endif

// ---- rtl/eq3rl_pkg.sv ----
// Types shared by the queue-3 limit register bank and its shaper.
// Assumes eq3rl_defines.svh supplies all numeric constants.
package eq3rl_pkg;

  // Result of decoding one register address.
  typedef struct packed {
    logic lim_hit;
    logic fix_hit;
    logic [2:0] idx;
  } eq3rl_dec_t;

  // Whole state of the register bank.
  typedef struct packed {
    logic [4:0][6:0] limit;
    logic [7:0] rdata;
    logic ack;
    logic top_prio;
    logic [6:0] tick_cnt;
    logic tick;
  } eq3rl_top_t;

  // Whole state of one port shaper.
  typedef struct packed {
    logic [11:0] credit;
  } eq3rl_shp_t;

endpackage

// ---- rtl/eq3rl_regs.sv ----
// Queue-3 egress limit registers for five ports, the fixed test registers
// beside them, and the per-port priority-3 shapers they steer.
// Assumes byte register strobes synchronous to clk, one access per cycle.
`timescale 1ns/10ps
`include "eq3rl_defines.svh"
module eq3rl_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  input wire logic four_queue_mode,
  input wire logic per_queue_mode,
  input wire logic [4:0] q3_byte_out,
  output logic [4:0] q3_allow,
  output logic q3_top_prio,
  output logic [4:0][6:0] q3_base_code
);

  eq3rl_pkg::eq3rl_top_t s;
  eq3rl_pkg::eq3rl_top_t next_s;
  eq3rl_pkg::eq3rl_dec_t wdec;
  eq3rl_pkg::eq3rl_dec_t rdec;

  // =====================================================================
  // Address decoding, shared by the write and read paths.
  function automatic eq3rl_pkg::eq3rl_dec_t eq3rl_decode(
    input logic [7:0] a
  );
    eq3rl_pkg::eq3rl_dec_t d;
    logic [4:0][7:0] lim_ofs;
    logic [4:0][7:0] fix_ofs;
    d = '0;
    lim_ofs = {`EQ3RL_OFS_LIM_P5, `EQ3RL_OFS_LIM_P4, `EQ3RL_OFS_LIM_P3,
               `EQ3RL_OFS_LIM_P2, `EQ3RL_OFS_LIM_P1};
    fix_ofs = {`EQ3RL_OFS_FIX_5, `EQ3RL_OFS_FIX_4, `EQ3RL_OFS_FIX_3,
               `EQ3RL_OFS_FIX_2, `EQ3RL_OFS_FIX_1};
    for (int i = 0; i < `EQ3RL_NPORT; i++) begin
      if (a == lim_ofs[i]) begin
        d.lim_hit = 1'b1;
        d.idx = 3'(i);
      end
      if (a == fix_ofs[i]) begin
        d.fix_hit = 1'b1;
        d.idx = 3'(i);
      end
    end
    return d;
  endfunction

  // Constant contents of the fixed registers.
  function automatic logic [7:0] eq3rl_fixed(input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      3'h0: v = `EQ3RL_RST_FIX_1;
      3'h1: v = `EQ3RL_RST_FIX_2;
      3'h2: v = `EQ3RL_RST_FIX_3;
      3'h3: v = `EQ3RL_RST_FIX_4;
      3'h4: v = `EQ3RL_RST_FIX_5;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign wdec = eq3rl_decode(reg_addr);
  assign rdec = eq3rl_decode(reg_addr);

  // =====================================================================
  // Next state: register writes, read data, tick divider, priority flag.
  always_comb begin
    next_s = s;
    next_s.ack = (reg_wr || reg_rd) && (wdec.lim_hit || wdec.fix_hit);
    // Only the code field stores; bit 7 and fixed registers drop writes.
    if (reg_wr && wdec.lim_hit) begin
      next_s.limit[wdec.idx] = reg_wdata[`EQ3RL_CODE_MSB:0];
    end
    if (reg_rd) begin
      if (rdec.lim_hit) begin
        next_s.rdata = {1'b0, s.limit[rdec.idx]};
      end else if (rdec.fix_hit) begin
        next_s.rdata = eq3rl_fixed(rdec.idx);
      end else begin
        next_s.rdata = 8'h00;
      end
    end
    // One tick pulse per microsecond feeds every shaper.
    if (s.tick_cnt == 7'(`EQ3RL_TICK_CYC - 1)) begin
      next_s.tick_cnt = 7'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 7'h01;
      next_s.tick = 1'b0;
    end
    next_s.top_prio = four_queue_mode;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs. The codes also serve as the base for lower-queue ratios.
  assign reg_rdata = s.rdata;
  assign reg_ack = s.ack;
  assign q3_top_prio = s.top_prio;
  assign q3_base_code = s.limit;

  // =====================================================================
  // One shaper per port, shaping only in per-queue limit mode.
  for (genvar p = 0; p < `EQ3RL_NPORT; p++) begin : g_port
    eq3rl_shape_if u_if ();
    assign u_if.tick = s.tick;
    assign u_if.code = s.limit[p];
    assign u_if.shape_en = per_queue_mode;
    assign u_if.byte_out = q3_byte_out[p];
    assign q3_allow[p] = u_if.allow;
    eq3rl_shaper u_shaper (
      .clk(clk),
      .resetn(resetn),
      .sif(u_if.shp)
    );
  end

  // =====================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_rst_zero;
    $rose(resetn) |-> (q3_base_code == '0) && !reg_ack;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("Limit codes not zero after reset.");

  property p_wr_p1;
    reg_wr && (reg_addr == 8'hBE) |=>
      q3_base_code[0] == $past(reg_wdata[6:0]);
  endproperty
  a_wr_p1: assert property (p_wr_p1)
    else $error("Port 1 limit write not stored.");

  property p_wr_p5;
    reg_wr && (reg_addr == 8'hFE) |=>
      (q3_base_code[4] == $past(reg_wdata[6:0])) &&
      ($past(q3_base_code[3:0]) == q3_base_code[3:0]);
  endproperty
  a_wr_p5: assert property (p_wr_p5)
    else $error("Port 5 write wrong or touched other ports.");

  property p_rd_p3;
    reg_rd && !reg_wr && (reg_addr == 8'hDE) |=>
      reg_rdata == {1'b0, $past(q3_base_code[2])};
  endproperty
  a_rd_p3: assert property (p_rd_p3)
    else $error("Port 3 limit read back wrong.");

  property p_fixed_cf;
    reg_rd && (reg_addr == 8'hCF) |=> (reg_rdata == 8'h15) && reg_ack;
  endproperty
  a_fixed_cf: assert property (p_fixed_cf)
    else $error("Register 0xCF did not read 0x15.");

  property p_fixed_ef;
    reg_rd && (reg_addr == 8'hEF) |=> (reg_rdata == 8'h32) && reg_ack;
  endproperty
  a_fixed_ef: assert property (p_fixed_ef)
    else $error("Register 0xEF did not read 0x32.");

  property p_prio;
    four_queue_mode |=> q3_top_prio;
  endproperty
  a_prio: assert property (p_prio)
    else $error("Queue 3 not flagged top priority.");

  property p_no_shape;
    !per_queue_mode |-> (q3_allow == 5'h1F);
  endproperty
  a_no_shape: assert property (p_no_shape)
    else $error("Queue 3 blocked outside per-queue mode.");

  // A mapped offset has 0xE or 0xF low and 0xB or more high.
  property p_ack_hit;
    (reg_wr || reg_rd) && (reg_addr[3:1] == 3'h7) &&
      (reg_addr[7:4] >= 4'hB) |=> reg_ack;
  endproperty
  a_ack_hit: assert property (p_ack_hit)
    else $error("Mapped access not acknowledged.");

  // Any other offset must stay silent so software sees no register.
  property p_ack_miss;
    (reg_wr || reg_rd) && !((reg_addr[3:1] == 3'h7) &&
      (reg_addr[7:4] >= 4'hB)) |=> !reg_ack;
  endproperty
  a_ack_miss: assert property (p_ack_miss)
    else $error("Unmapped access acknowledged.");

  // Read data holds between reads, so a slow reader still sees it.
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read data changed without a read.");

  // The reserved top bit of every limit register reads as zero.
  property p_bit7;
    reg_rd && (reg_addr[3:0] == 4'hE) && (reg_addr[7:4] >= 4'hB)
      |=> !reg_rdata[7];
  endproperty
  a_bit7: assert property (p_bit7)
    else $error("Limit register bit 7 read as one.");

  // Writes to the fixed registers must leave every limit code alone.
  property p_fixed_wr;
    reg_wr && (reg_addr[3:0] == 4'hF) |=> $stable(q3_base_code);
  endproperty
  a_fixed_wr: assert property (p_fixed_wr)
    else $error("Fixed register write changed a limit code.");

  // The credit tick must come exactly once per microsecond.
  localparam int tick_gap = `EQ3RL_TICK_CYC;
  property p_tick_gap;
    s.tick |-> ##tick_gap s.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("Credit tick period is wrong.");

  c_wr_rd: cover property (reg_wr && (reg_addr == 8'hEE) ##1
                           reg_rd && (reg_addr == 8'hEE));
  c_block: cover property (per_queue_mode && !q3_allow[0]);
  c_fixed: cover property (reg_rd && (reg_addr == 8'hBF));
  c_refill: cover property (per_queue_mode && s.tick ##1 q3_allow[0]);
  c_prio: cover property (four_queue_mode ##1 q3_top_prio);

endmodule

// ---- rtl/eq3rl_shape_if.sv ----
// Carrier between the register bank and one per-port shaper.
// Assumes both ends run on the switch system clock.
`timescale 1ns/10ps
interface eq3rl_shape_if;
  logic tick;
  logic [6:0] code;
  logic shape_en;
  logic byte_out;
  logic allow;
  modport ctl (output tick, output code, output shape_en,
               output byte_out, input allow);
  modport shp (input tick, input code, input shape_en,
               input byte_out, output allow);
endinterface

// ---- rtl/eq3rl_shaper.sv ----
// Byte credit shaper for the priority-3 egress queue of one port.
// Assumes a tick pulse every microsecond and one byte_out per byte sent.
`timescale 1ns/10ps
`include "eq3rl_defines.svh"
module eq3rl_shaper (
  input wire logic clk,
  input wire logic resetn,
  eq3rl_shape_if.shp sif
);

  eq3rl_pkg::eq3rl_shp_t s;
  eq3rl_pkg::eq3rl_shp_t next_s;
  logic [12:0] sum;

  // =====================================================================
  // Credit update: add the code on each tick, spend one per byte.
  always_comb begin
    next_s = s;
    sum = 13'(s.credit) + 13'(sif.code);
    if (sif.tick) begin
      next_s.credit = (sum > 13'(`EQ3RL_CREDIT_MAX)) ?
                      `EQ3RL_CREDIT_MAX : sum[11:0];
    end
    if (sif.byte_out && (next_s.credit != 12'h000)) begin
      next_s.credit = next_s.credit - 12'h001;
    end
    if (!sif.shape_en || (sif.code == `EQ3RL_RST_CODE)) begin
      next_s.credit = 12'h000;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Sending is allowed while credit remains, shaping is off, or the limit code is zero.
  assign sif.allow = !sif.shape_en || (sif.code == `EQ3RL_RST_CODE) ||
                     (s.credit != 12'h000);

  // =====================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_block_empty;
    sif.shape_en && (sif.code != 7'h00) && (s.credit == 12'h000)
      |-> !sif.allow;
  endproperty
  a_block_empty: assert property (p_block_empty)
    else $error("Queue 3 allowed with no credit.");

  property p_exact_gain;
    sif.tick && !sif.byte_out && sif.shape_en && (sif.code != 7'h00) &&
      (s.credit < 12'h700)
      |=> s.credit == $past(s.credit) + 12'($past(sif.code));
  endproperty
  a_exact_gain: assert property (p_exact_gain)
    else $error("Credit gain differs from the limit code.");

  property p_cap;
    s.credit <= `EQ3RL_CREDIT_MAX;
  endproperty
  a_cap: assert property (p_cap)
    else $error("Credit above its ceiling.");

endmodule

// ---- testbench/test_eq3rl_regs.sv ----
// Self-checking bench for the queue-3 egress limit register bank.
// Assumes the design files under rtl/ and a 100 MHz clock, 10 ns period.
`timescale 1ns/10ps
module test_eq3rl_regs;
  // ===================================================================
  // Signals and stimulus table.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] rst;
    logic [7:0] wdata;
    logic [7:0] exp;
  } eq3rl_row_t;
  logic clk, resetn, reg_wr, reg_rd, reg_ack;
  logic four_queue_mode, per_queue_mode, ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic [4:0] q3_byte_out, q3_allow;
  logic q3_top_prio;
  logic [4:0][6:0] q3_base_code;
  eq3rl_row_t rows [10];
  int fail_count, checked, cycles, n;

  eq3rl_regs i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .four_queue_mode(four_queue_mode), .per_queue_mode(per_queue_mode),
    .q3_byte_out(q3_byte_out), .q3_allow(q3_allow),
    .q3_top_prio(q3_top_prio), .q3_base_code(q3_base_code));

  // ===================================================================
  // Clock and hang guard; the run needs well under 2000 cycles.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  // ===================================================================
  // Shared tasks: compare, one register access, verdict.
  task automatic chk(input string name, input logic [34:0] seen,
                     input logic [34:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the strobe for one edge and samples the answer one cycle on.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = w;
    reg_rd = ~w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    q = reg_rdata;
    ack = reg_ack;
  endtask

  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ===================================================================
  // Main sequence: table loop, then hand-written cases.
  initial begin
    {resetn, reg_wr, reg_rd, four_queue_mode, per_queue_mode} = '0;
    {reg_addr, reg_wdata, q3_byte_out} = '0;
    rows = '{'{8'hbe, 8'h00, 8'h85, 8'h05}, '{8'hce, 8'h00, 8'h7f, 8'h7f},
      '{8'hde, 8'h00, 8'h80, 8'h00}, '{8'hee, 8'h00, 8'h2a, 8'h2a},
      '{8'hfe, 8'h00, 8'hff, 8'h7f}, '{8'hbf, 8'h80, 8'hff, 8'h80},
      '{8'hcf, 8'h15, 8'h00, 8'h15}, '{8'hdf, 8'h0c, 8'hff, 8'h0c},
      '{8'hef, 8'h32, 8'h00, 8'h32}, '{8'hff, 8'h00, 8'haa, 8'h00}};
    repeat (8) @(posedge clk);
    #1;
    // Outputs while reset is held: no data, no ack, nothing shaped.
    chk("in reset", {reg_rdata, reg_ack, q3_allow}, 14'h001f);
    resetn = 1'b1;
    // Reset values of all ten registers.
    foreach (rows[i]) begin
      acc(1'b0, rows[i].addr, 8'h00);
      chk("reset read", {q, ack}, {rows[i].rst, 1'b1});
    end
    // Write then read back; bit 7 and the fixed registers keep their value.
    foreach (rows[i]) begin
      acc(1'b1, rows[i].addr, rows[i].wdata);
      chk("write ack", ack, 1'b1);
      acc(1'b0, rows[i].addr, 8'h00);
      chk("readback", q, rows[i].exp);
    end
    chk("code", q3_base_code, {7'h7f, 7'h2a, 7'h0, 7'h7f, 7'h5});
    // An unmapped address gives no acknowledge and reads zero.
    acc(1'b0, 8'h10, 8'h00);
    chk("unmapped", {q, ack}, 9'h000);
    // Queue 3 is marked top priority only in four-queue mode.
    four_queue_mode = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("top prio on", q3_top_prio, 1'b1);
    four_queue_mode = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("top prio off", q3_top_prio, 1'b0);
    // Port 1 gets 5 bytes a tick; the other ports run unshaped.
    acc(1'b1, 8'hce, 8'h00);
    acc(1'b1, 8'hee, 8'h00);
    acc(1'b1, 8'hfe, 8'h00);
    per_queue_mode = 1'b1;
    // Credit starts empty, so port 1 is blocked before any edge passes.
    #1;
    chk("allow empty", q3_allow, 5'b11110);
    n = 0;
    while (q3_allow[0] !== 1'b1 && n < 150) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("allow after tick", q3_allow, 5'b11111);
    // Exactly five bytes of credit: four spent still allow, five do not.
    q3_byte_out = 5'b00001;
    repeat (4) @(posedge clk);
    #1;
    chk("allow four spent", q3_allow, 5'b11111);
    @(posedge clk);
    #1;
    q3_byte_out = 5'b00000;
    chk("allow spent", q3_allow, 5'b11110);
    per_queue_mode = 1'b0;
    @(posedge clk);
    #1;
    chk("allow unshaped", q3_allow, 5'b11111);
    // A reset in mid-run clears every limit code.
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk("codes after reset", q3_base_code, 35'h0);
    acc(1'b0, 8'hbe, 8'h00);
    chk("limit after reset", q, 8'h00);
    summarize();
  end
endmodule
